//--- rtl/rcs_pkg.sv
// Constants, types and decode helpers for the reset-cause and start-up sequencer.
// Assumes one 100 MHz system clock and a 32-bit AXI4-Lite register port.
//
// Overview of operation
// - Power-control register at index 8Eh holds the last reset kind in two low flags.
// - Power-on flag, bit 1, cleared by power-on reset, kept by every other reset.
// - Brown-out flag, bit 0, undefined after power-on, cleared by brown-out reset.
// - With brown-out mode 00 the brown-out flag means nothing.
// - Crystal classes add 1024 oscillator periods; other classes only the power-up delay.
// - Power-on: power-on flag 0, both status flags 1; brown-out: brown-out flag 0.
// - Pin reset outside sleep keeps all four flags; watchdog reset clears only the expiry flag.
// - Pin reset in sleep sets expiry, clears sleep flag; watchdog wake clears both.
// - Pin or watchdog reset clears wake enable; power-up resets load 01qq.
// - Wake-ups leave power-control untouched and update only the two status flags.
// - Core status loads 0001 1xxx on power-up resets, 000q quuu otherwise.
// - Ten-bit configuration word layout: mode, protects, pin, delay, watchdog, oscillator.
// - Power-up delay of 64 ms on the 31 kHz clock, only after power-up resets.
// - Mode 01 follows the software enable; mode 10 disables detection in sleep.
// - Brown-out during the power-up delay restarts the whole delay after recovery.

`default_nettype none

package rcs_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam int unsigned AXI_ADDR_W = 12;
  localparam logic [7:0] CORE_STATUS_IDX = 8'h03;
  localparam logic [7:0] POWER_CONTROL_IDX = 8'h8e;
  localparam logic [11:0] CONFIG_ADDR = 12'h400;
  localparam logic [11:0] IRQ_STATUS_ADDR = 12'h404;
  localparam logic [11:0] IRQ_MASK_ADDR = 12'h408;
  localparam logic [11:0] SEQ_STATE_ADDR = 12'h40c;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  // ****************************************
  // Field positions and reset values
  // ****************************************
  localparam int unsigned CS_EXPIRY_BIT = 4;
  localparam int unsigned CS_SLEEP_BIT = 3;
  localparam int unsigned PC_WAKE_EN_BIT = 5;
  localparam int unsigned PC_SW_BOR_BIT = 4;
  localparam int unsigned PC_POR_BIT = 1;
  localparam int unsigned PC_BOR_BIT = 0;
  localparam logic [7:0] CORE_STATUS_POR = 8'h18;
  localparam logic [7:0] CORE_STATUS_SW_MASK = 8'he7;
  localparam logic [7:0] POWER_CONTROL_POR = 8'h10;
  localparam logic [7:0] POWER_CONTROL_SW_MASK = 8'h33;
  localparam logic [9:0] CONFIG_RESET = 10'h3ff;
  localparam int unsigned IRQ_W = 5;
  localparam int unsigned IRQ_POR = 0;
  localparam int unsigned IRQ_BOR = 1;
  localparam int unsigned IRQ_WDT = 2;
  localparam int unsigned IRQ_PIN = 3;
  localparam int unsigned IRQ_WAKE = 4;
  localparam logic [4:0] IRQ_STATUS_POR = 5'h01;

  // ****************************************
  // Timing
  // ****************************************
  localparam int unsigned POWERUP_DELAY_TIMER_MS = 64;
  localparam int unsigned LFO_HZ = 31000;
  localparam int unsigned POWERUP_DELAY_TIMER_TICKS = POWERUP_DELAY_TIMER_MS * LFO_HZ / 1000;
  localparam int unsigned OST_TICKS = 1024;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [2:0] {
    OSC_LOW_POWER_CRYSTAL = 3'h0,
    OSC_STANDARD_CRYSTAL = 3'h1,
    OSC_HIGH_SPEED_CRYSTAL = 3'h2,
    OSC_EXTERNAL_CLOCK_INPUT = 3'h3,
    OSC_INTERNAL_OSCILLATOR_IO = 3'h4,
    OSC_INTERNAL_OSCILLATOR_CLKOUT = 3'h5,
    OSC_RESISTOR_CAPACITOR_IO = 3'h6,
    OSC_RESISTOR_CAPACITOR_CLKOUT = 3'h7
  } rcs_osc_e;

  typedef enum logic [1:0] {
    BOR_OFF = 2'h0,
    BOR_SOFTWARE = 2'h1,
    BOR_AWAKE_ONLY = 2'h2,
    BOR_ALWAYS = 2'h3
  } rcs_bor_e;

  typedef enum logic [1:0] {
    SEQ_RUN = 2'b00,
    SEQ_SUPPLY = 2'b01,
    SEQ_POWERUP_DELAY_TIMER = 2'b11,
    SEQ_OST = 2'b10
  } rcs_seq_e;

  typedef enum logic [2:0] {
    REG_NONE, REG_CORE, REG_POWER, REG_CONFIG, REG_IRQ_STATUS, REG_IRQ_MASK, REG_SEQ
  } rcs_reg_e;

  typedef struct packed {
    rcs_bor_e brownout_mode_select;
    logic data_protect;
    logic code_protect;
    logic ext_reset_pin_enable;
    logic powerup_delay_disable;
    logic watchdog_enable_cfg;
    rcs_osc_e oscillator_select;
  } rcs_cfg_s;

  typedef struct packed {
    logic brownout_detect;
    logic watchdog_timeout;
    logic sleep_enter;
    logic wake_interrupt;
  } rcs_evt_s;

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic is_crystal(input rcs_osc_e osc);
    is_crystal = (osc == OSC_LOW_POWER_CRYSTAL) || (osc == OSC_STANDARD_CRYSTAL) ||
                 (osc == OSC_HIGH_SPEED_CRYSTAL);
  endfunction : is_crystal

  function automatic rcs_reg_e decode_reg(input logic [AXI_ADDR_W-1:0] addr);
    logic [9:0] word;
    word = addr[AXI_ADDR_W-1:2];
    if (word == {2'b00, CORE_STATUS_IDX}) decode_reg = REG_CORE;
    else if (word == {2'b00, POWER_CONTROL_IDX}) decode_reg = REG_POWER;
    else if (word == CONFIG_ADDR[11:2]) decode_reg = REG_CONFIG;
    else if (word == IRQ_STATUS_ADDR[11:2]) decode_reg = REG_IRQ_STATUS;
    else if (word == IRQ_MASK_ADDR[11:2]) decode_reg = REG_IRQ_MASK;
    else if (word == SEQ_STATE_ADDR[11:2]) decode_reg = REG_SEQ;
    else decode_reg = REG_NONE;
  endfunction : decode_reg

endpackage : rcs_pkg

`default_nettype wire

//--- rtl/rcs_reset_cause_seq.sv
// Reset-cause flags, start-up hold sequencer and AXI4-Lite register slave.
// Assumes event inputs and tick strobes are synchronous to clk_sys.

`default_nettype none

module rcs_reset_cause_seq #(
  parameter int unsigned POWERUP_DELAY_TIMER_TICKS = rcs_pkg::POWERUP_DELAY_TIMER_TICKS,
  parameter int unsigned OST_TICKS = rcs_pkg::OST_TICKS,
  parameter int unsigned CNT_W = 11,
  parameter logic [9:0] CFG_RESET = rcs_pkg::CONFIG_RESET
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic ce,
  // Event sources and tick strobes
  input wire rcs_pkg::rcs_evt_s evt,
  input wire logic ext_reset_pin_n,
  input wire logic lfo_tick,
  input wire logic osc_tick,
  // Block outputs
  output logic core_reset_hold,
  output logic in_sleep,
  output logic brownout_detect_enable,
  output logic irq,
  // AXI4-Lite slave
  input wire logic [rcs_pkg::AXI_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [rcs_pkg::AXI_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  // ****************************************
  // Parameter check
  // ****************************************
  if (POWERUP_DELAY_TIMER_TICKS < 1 || OST_TICKS < 1 || POWERUP_DELAY_TIMER_TICKS > 2 ** CNT_W || OST_TICKS > 2 ** CNT_W)
  begin : g_bad_counts
    $error("Tick counts do not fit the phase counter");
  end

  // ****************************************
  // State
  // ****************************************
  rcs_pkg::rcs_seq_e state_q, state_d;
  logic [CNT_W-1:0] cnt_q;
  logic [7:0] core_status_q;
  logic [7:0] power_control_q;
  rcs_pkg::rcs_cfg_s cfg_q;
  logic [rcs_pkg::IRQ_W-1:0] irq_status_q, irq_mask_q, irq_set;
  logic in_sleep_q, pin_prev_q, hold_q, bor_en_q, irq_q;
  logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
  logic [1:0] bresp_q, rresp_q;
  logic [31:0] rdata_q, wdata_q, rd_word;
  logic [3:0] wstrb_q;
  logic [rcs_pkg::AXI_ADDR_W-1:0] awaddr_q;
  rcs_pkg::rcs_reg_e wr_sel, rd_sel;
  logic wr_en, rd_take, wr_core, wr_power;
  logic bor_en, bor_hit, bor_start, pin_active, pin_start;
  logic wdt_hit, wdt_reset, wdt_wake, wake_irq, sleep_go, quiet, crystal;
  logic powerup_delay_timer_done, ost_done;

  // ****************************************
  // Event qualification
  // ****************************************
  always_comb
  begin
    unique case (cfg_q.brownout_mode_select)
      rcs_pkg::BOR_OFF: bor_en = 1'b0;
      rcs_pkg::BOR_SOFTWARE: bor_en = power_control_q[rcs_pkg::PC_SW_BOR_BIT];
      rcs_pkg::BOR_AWAKE_ONLY: bor_en = !in_sleep_q;
      rcs_pkg::BOR_ALWAYS: bor_en = 1'b1;
    endcase
  end

  assign crystal = rcs_pkg::is_crystal(cfg_q.oscillator_select);
  assign bor_hit = evt.brownout_detect && bor_en;
  assign bor_start = bor_hit && (state_q != rcs_pkg::SEQ_SUPPLY);
  assign pin_active = cfg_q.ext_reset_pin_enable && !ext_reset_pin_n;
  assign pin_start = pin_active && !pin_prev_q && !bor_hit;
  assign quiet = (state_q == rcs_pkg::SEQ_RUN) && !pin_active && !bor_hit;
  assign wdt_hit = evt.watchdog_timeout && cfg_q.watchdog_enable_cfg && quiet;
  assign wdt_reset = wdt_hit && !in_sleep_q;
  assign wdt_wake = wdt_hit && in_sleep_q;
  assign wake_irq = evt.wake_interrupt && in_sleep_q && quiet && !wdt_hit;
  assign sleep_go = evt.sleep_enter && !in_sleep_q && quiet && !wdt_hit;

  // ****************************************
  // Start-up sequencer
  // ****************************************
  assign powerup_delay_timer_done = lfo_tick && (cnt_q == CNT_W'(POWERUP_DELAY_TIMER_TICKS - 1));
  assign ost_done = osc_tick && (cnt_q == CNT_W'(OST_TICKS - 1));

  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      rcs_pkg::SEQ_SUPPLY:
      begin
        if (!bor_hit)
        begin
          if (!cfg_q.powerup_delay_disable) state_d = rcs_pkg::SEQ_POWERUP_DELAY_TIMER;
          else if (crystal) state_d = rcs_pkg::SEQ_OST;
          else state_d = rcs_pkg::SEQ_RUN;
        end
      end
      rcs_pkg::SEQ_POWERUP_DELAY_TIMER:
      begin
        if (powerup_delay_timer_done) state_d = crystal ? rcs_pkg::SEQ_OST : rcs_pkg::SEQ_RUN;
      end
      rcs_pkg::SEQ_OST:
      begin
        if (ost_done) state_d = rcs_pkg::SEQ_RUN;
      end
      rcs_pkg::SEQ_RUN:
      begin
        if ((wake_irq || wdt_wake) && crystal) state_d = rcs_pkg::SEQ_OST;
      end
    endcase
    if (bor_hit) state_d = rcs_pkg::SEQ_SUPPLY;
  end

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn) state_q <= rcs_pkg::SEQ_SUPPLY;
    else if (ce) state_q <= state_d;
  end

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn) cnt_q <= '0;
    else if (ce)
    begin
      if (state_d != state_q) cnt_q <= '0;
      else if (state_q == rcs_pkg::SEQ_POWERUP_DELAY_TIMER && lfo_tick) cnt_q <= cnt_q + 1'b1;
      else if (state_q == rcs_pkg::SEQ_OST && osc_tick) cnt_q <= cnt_q + 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      hold_q <= 1'b1;
      pin_prev_q <= 1'b0;
      bor_en_q <= 1'b0;
      in_sleep_q <= 1'b0;
    end
    else if (ce)
    begin
      hold_q <= (state_d != rcs_pkg::SEQ_RUN) || pin_active || wdt_reset;
      pin_prev_q <= pin_active;
      bor_en_q <= bor_en;
      if (bor_hit || pin_start || wdt_hit || wake_irq) in_sleep_q <= 1'b0;
      else if (sleep_go) in_sleep_q <= 1'b1;
    end
  end

  // ****************************************
  // Reset-cause registers
  // ****************************************
  assign wr_core = wr_en && (wr_sel == rcs_pkg::REG_CORE) && wstrb_q[0];
  assign wr_power = wr_en && (wr_sel == rcs_pkg::REG_POWER) && wstrb_q[0];

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn) core_status_q <= rcs_pkg::CORE_STATUS_POR;
    else if (ce)
    begin
      if (bor_hit) core_status_q <= {3'b000, 2'b11, core_status_q[2:0]};
      else if (pin_start && in_sleep_q) core_status_q <= {3'b000, 2'b10, core_status_q[2:0]};
      else if (pin_start) core_status_q <= {3'b000, core_status_q[4:0]};
      else if (wdt_reset) core_status_q <= {3'b000, 1'b0, core_status_q[3:0]};
      else if (wdt_wake) core_status_q <= {core_status_q[7:5], 2'b00, core_status_q[2:0]};
      else if (wake_irq) core_status_q <= {core_status_q[7:5], 2'b10, core_status_q[2:0]};
      else if (sleep_go) core_status_q <= {core_status_q[7:5], 2'b10, core_status_q[2:0]};
      else if (wr_core)
        core_status_q <= (wdata_q[7:0] & rcs_pkg::CORE_STATUS_SW_MASK) |
                         (core_status_q & ~rcs_pkg::CORE_STATUS_SW_MASK);
    end
  end

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn) power_control_q <= rcs_pkg::POWER_CONTROL_POR;
    else if (ce)
    begin
      if (bor_hit)
        power_control_q <= {2'b00, 2'b01, 2'b00, power_control_q[1], 1'b0};
      else if (pin_start || wdt_reset)
        power_control_q <= power_control_q & ~(8'h01 << rcs_pkg::PC_WAKE_EN_BIT);
      else if (wr_power)
        power_control_q <= wdata_q[7:0] & rcs_pkg::POWER_CONTROL_SW_MASK;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      cfg_q <= CFG_RESET;
      irq_mask_q <= '0;
    end
    else if (ce && wr_en)
    begin
      if (wr_sel == rcs_pkg::REG_CONFIG && wstrb_q[0]) cfg_q[7:0] <= wdata_q[7:0];
      if (wr_sel == rcs_pkg::REG_CONFIG && wstrb_q[1]) cfg_q[9:8] <= wdata_q[9:8];
      if (wr_sel == rcs_pkg::REG_IRQ_MASK && wstrb_q[0]) irq_mask_q <= wdata_q[rcs_pkg::IRQ_W-1:0];
    end
  end

  // ****************************************
  // Interrupt status
  // ****************************************
  always_comb
  begin
    irq_set = '0;
    irq_set[rcs_pkg::IRQ_BOR] = bor_start;
    irq_set[rcs_pkg::IRQ_WDT] = wdt_reset;
    irq_set[rcs_pkg::IRQ_PIN] = pin_start;
    irq_set[rcs_pkg::IRQ_WAKE] = wdt_wake || wake_irq;
  end

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      irq_status_q <= rcs_pkg::IRQ_STATUS_POR;
      irq_q <= 1'b0;
    end
    else if (ce)
    begin
      if (rd_take && rd_sel == rcs_pkg::REG_IRQ_STATUS) irq_status_q <= irq_set;
      else irq_status_q <= irq_status_q | irq_set;
      irq_q <= |(irq_status_q & irq_mask_q);
    end
  end

  // ****************************************
  // AXI4-Lite write channel
  // ****************************************
  assign wr_en = !awready_q && !wready_q && !bvalid_q;
  assign wr_sel = rcs_pkg::decode_reg(awaddr_q);

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      awready_q <= 1'b1;
      wready_q <= 1'b1;
      bvalid_q <= 1'b0;
      bresp_q <= rcs_pkg::RESP_OKAY;
      awaddr_q <= '0;
      wdata_q <= '0;
      wstrb_q <= '0;
    end
    else if (ce)
    begin
      if (s_axi_awvalid && awready_q)
      begin
        awaddr_q <= s_axi_awaddr;
        awready_q <= 1'b0;
      end
      if (s_axi_wvalid && wready_q)
      begin
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
        wready_q <= 1'b0;
      end
      if (wr_en)
      begin
        bvalid_q <= 1'b1;
        bresp_q <= (wr_sel == rcs_pkg::REG_NONE) ? rcs_pkg::RESP_DECERR : rcs_pkg::RESP_OKAY;
        awready_q <= 1'b1;
        wready_q <= 1'b1;
      end
      else if (bvalid_q && s_axi_bready) bvalid_q <= 1'b0;
    end
  end

  // ****************************************
  // AXI4-Lite read channel
  // ****************************************
  assign rd_take = s_axi_arvalid && arready_q;
  assign rd_sel = rcs_pkg::decode_reg(s_axi_araddr);

  always_comb
  begin
    rd_word = '0;
    unique case (rd_sel)
      rcs_pkg::REG_CORE: rd_word[7:0] = core_status_q;
      rcs_pkg::REG_POWER: rd_word[7:0] = power_control_q;
      rcs_pkg::REG_CONFIG: rd_word[9:0] = cfg_q;
      rcs_pkg::REG_IRQ_STATUS: rd_word[rcs_pkg::IRQ_W-1:0] = irq_status_q;
      rcs_pkg::REG_IRQ_MASK: rd_word[rcs_pkg::IRQ_W-1:0] = irq_mask_q;
      rcs_pkg::REG_SEQ: rd_word[4:0] = {bor_en_q, in_sleep_q, hold_q, state_q};
      rcs_pkg::REG_NONE: rd_word = '0;
    endcase
  end

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= rcs_pkg::RESP_OKAY;
    end
    else if (ce)
    begin
      if (rd_take)
      begin
        arready_q <= 1'b0;
        rvalid_q <= 1'b1;
        rdata_q <= rd_word;
        rresp_q <= (rd_sel == rcs_pkg::REG_NONE) ? rcs_pkg::RESP_DECERR : rcs_pkg::RESP_OKAY;
      end
      else if (rvalid_q && s_axi_rready)
      begin
        rvalid_q <= 1'b0;
        arready_q <= 1'b1;
      end
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign core_reset_hold = hold_q;
  assign in_sleep = in_sleep_q;
  assign brownout_detect_enable = bor_en_q;
  assign irq = irq_q;
  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clk_sys iff ce);
  endclocking
  default disable iff (!resetn);

  a_bor_flags_load: assert property (bor_hit |=> power_control_q[1:0] == {$past(power_control_q[1]), 1'b0}
    && core_status_q[4:3] == 2'b11 && state_q == rcs_pkg::SEQ_SUPPLY)
    else $error("Brown-out did not load its flags");
  a_pin_keeps_flags: assert property (pin_start && !in_sleep_q |=>
    core_status_q[4:3] == $past(core_status_q[4:3]) && power_control_q[1:0] == $past(power_control_q[1:0]))
    else $error("Pin reset changed a cause flag");
  a_wdt_reset_flags: assert property (wdt_reset |=> !core_status_q[4] && core_status_q[3] == $past(core_status_q[3])
    && hold_q)
    else $error("Watchdog reset flags wrong");
  a_pin_sleep_flags: assert property (pin_start && in_sleep_q |=> core_status_q[4:3] == 2'b10 && !in_sleep_q)
    else $error("Pin reset in sleep flags wrong");
  a_wake_keeps_power: assert property ((wdt_wake || wake_irq) && !wr_power |=>
    power_control_q == $past(power_control_q) && core_status_q[7:5] == $past(core_status_q[7:5]))
    else $error("Wake-up disturbed power-control");
  a_wake_wdt_flags: assert property (wdt_wake |=> core_status_q[4:3] == 2'b00)
    else $error("Watchdog wake flags wrong");
  a_wake_enable_clear: assert property (pin_start || wdt_reset |=> !power_control_q[5] && core_status_q[7:5] == 3'b000)
    else $error("Reset kept wake enable or bank bits");
  a_powerup_delay_timer_exit_count: assert property (state_q == rcs_pkg::SEQ_POWERUP_DELAY_TIMER && state_d != rcs_pkg::SEQ_POWERUP_DELAY_TIMER && !bor_hit
    |-> lfo_tick && cnt_q == CNT_W'(POWERUP_DELAY_TIMER_TICKS - 1))
    else $error("Power-up delay ended at the wrong count");
  a_ost_exit_count: assert property (state_q == rcs_pkg::SEQ_OST && state_d == rcs_pkg::SEQ_RUN
    |-> osc_tick && cnt_q == CNT_W'(OST_TICKS - 1) && crystal)
    else $error("Start-up count ended wrong");
  a_phase_order: assert property (state_q == rcs_pkg::SEQ_POWERUP_DELAY_TIMER |=> state_q inside {rcs_pkg::SEQ_POWERUP_DELAY_TIMER,
    rcs_pkg::SEQ_OST, rcs_pkg::SEQ_RUN, rcs_pkg::SEQ_SUPPLY} && (state_q != rcs_pkg::SEQ_OST || crystal))
    else $error("Phase order broken");
  a_hold_covers: assert property (state_q != rcs_pkg::SEQ_RUN |-> hold_q)
    else $error("Core released during a hold phase");
  a_bor_restart: assert property (state_q == rcs_pkg::SEQ_POWERUP_DELAY_TIMER && bor_hit
    |=> state_q == rcs_pkg::SEQ_SUPPLY && cnt_q == '0)
    else $error("Brown-out did not restart the delay");
  a_mode_select: assert property ((cfg_q.brownout_mode_select == rcs_pkg::BOR_OFF
    || (cfg_q.brownout_mode_select == rcs_pkg::BOR_AWAKE_ONLY && in_sleep_q)) |=> !bor_en_q)
    else $error("Brown-out detection enabled against mode");

  c_por_to_run: cover property (state_q == rcs_pkg::SEQ_POWERUP_DELAY_TIMER ##1 state_q == rcs_pkg::SEQ_POWERUP_DELAY_TIMER [*2]
    ##[1:1000] state_q == rcs_pkg::SEQ_RUN);
  c_bor_restart: cover property (state_q == rcs_pkg::SEQ_POWERUP_DELAY_TIMER && bor_hit);
  c_wdt_wake: cover property (wdt_wake);
  c_pin_in_sleep: cover property (pin_start && in_sleep_q);

endmodule : rcs_reset_cause_seq

`default_nettype wire

//--- test/rcs_reset_cause_seq_bench.sv
// Self-checking bench for the reset-cause and start-up sequencer.
// Assumes rcs_pkg and rcs_reset_cause_seq are compiled first.
`default_nettype none
module rcs_reset_cause_seq_bench;
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************
  // Signals and instance
  // ****************************************
  logic clk_sys = 0, resetn = 0, ce = 1, ext_reset_pin_n = 1, lfo_tick = 0, osc_tick = 0;
  rcs_pkg::rcs_evt_s evt = '0;
  logic core_reset_hold, in_sleep, brownout_detect_enable, irq;
  logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, rdat;
  logic [3:0] s_axi_wstrb = '0;
  logic [1:0] s_axi_bresp, s_axi_rresp, rrsp, brsp;
  int n_mismatch = 0, compares = 0, cyc = 0, nh;
  rcs_reset_cause_seq #(.POWERUP_DELAY_TIMER_TICKS(4), .OST_TICKS(4)) rcs_reset_cause_seq_inst (
    .clk_sys(clk_sys), .resetn(resetn), .ce(ce), .evt(evt), .ext_reset_pin_n(ext_reset_pin_n),
    .lfo_tick(lfo_tick), .osc_tick(osc_tick), .core_reset_hold(core_reset_hold), .in_sleep(in_sleep),
    .brownout_detect_enable(brownout_detect_enable), .irq(irq),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
  // ****************************************
  // Tasks
  // ****************************************
  task automatic finish_test;
    if (n_mismatch == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : finish_test
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge clk_sys);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge clk_sys);
      if (s_axi_awready && s_axi_awvalid) s_axi_awvalid <= 1'b0;
      if (s_axi_wready && s_axi_wvalid) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    brsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    @(posedge clk_sys);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge clk_sys);
      if (s_axi_arready && s_axi_arvalid) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    rdat = s_axi_rdata;
    rrsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    chk(rdat, e);
  endtask : rd
  task automatic ev(input logic [3:0] v, input int n);
    @(posedge clk_sys);
    evt <= v;
    repeat (n) @(posedge clk_sys);
    evt <= '0;
    repeat (2) @(posedge clk_sys);
  endtask : ev
  task automatic wh;
    nh = 0;
    while (core_reset_hold !== 1'b0)
    begin
      @(posedge clk_sys);
      nh++;
    end
  endtask : wh
  task automatic pin;
    @(posedge clk_sys);
    ext_reset_pin_n <= 1'b0;
    repeat (3) @(posedge clk_sys);
    ext_reset_pin_n <= 1'b1;
    wh();
  endtask : pin
  // ****************************************
  // Clock, ticks, timeout, sequence
  // ****************************************
  always #5 clk_sys = ~clk_sys;
  always @(posedge clk_sys)
  begin
    lfo_tick <= ~lfo_tick;
    osc_tick <= ~osc_tick;
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      n_mismatch++;
      finish_test();
    end
  end
  initial
  begin
    repeat (3) @(posedge clk_sys);
    resetn <= 1'b1;
    wh();
    chk(nh < 4, 1'b1);
    rd(12'h00c, 8'h18);
    rd(12'h238, 8'h10);
    rd(12'h404, 8'h01);
    rd(12'h404, 8'h00);
    rd(12'h7f0, 8'h00);
    chk(rrsp, 2'h3);
    wr(12'h7f0, 32'h0, 4'h1);
    chk(brsp, 2'h3);
    wr(12'h400, 12'h329, 4'h3);
    chk(brsp, 2'h0);
    rd(12'h400, 12'h329);
    wr(12'h408, 8'h04, 4'h1);
    wr(12'h238, 8'h33, 4'h1);
    rd(12'h238, 8'h33);
    chk(brownout_detect_enable, 1'b1);
    ev(4'h4, 1);
    rd(12'h00c, 8'h08);
    rd(12'h238, 8'h13);
    chk(irq, 1'b1);
    rd(12'h404, 8'h04);
    repeat (2) @(posedge clk_sys);
    chk(irq, 1'b0);
    wh();
    ev(4'h2, 1);
    chk(in_sleep, 1'b1);
    ev(4'h4, 1);
    chk(core_reset_hold, 1'b1);
    rd(12'h00c, 8'h00);
    rd(12'h238, 8'h13);
    wh();
    ev(4'h2, 1);
    ev(4'h1, 1);
    rd(12'h00c, 8'h10);
    wh();
    ev(4'h2, 1);
    pin();
    rd(12'h00c, 8'h10);
    chk(in_sleep, 1'b0);
    wr(12'h00c, 8'hff, 4'h1);
    wr(12'h238, 8'h33, 4'h1);
    pin();
    rd(12'h00c, 8'h17);
    rd(12'h238, 8'h13);
    ev(4'h8, 4);
    wh();
    chk(nh >= 12, 1'b1);
    rd(12'h00c, 8'h1f);
    rd(12'h238, 8'h12);
    ev(4'h8, 4);
    repeat (4) @(posedge clk_sys);
    ev(4'h8, 2);
    wh();
    chk(nh >= 12, 1'b1);
    wr(12'h400, 12'h129, 4'h3);
    wr(12'h238, 8'h00, 4'h1);
    @(posedge clk_sys);
    chk(brownout_detect_enable, 1'b0);
    wr(12'h238, 8'h10, 4'h1);
    @(posedge clk_sys);
    chk(brownout_detect_enable, 1'b1);
    wr(12'h400, 12'h229, 4'h3);
    ev(4'h2, 1);
    chk(brownout_detect_enable, 1'b0);
    ev(4'h1, 1);
    chk(brownout_detect_enable, 1'b1);
    wh();
    wr(12'h400, 12'h029, 4'h3);
    ev(4'h8, 2);
    chk(core_reset_hold, 1'b0);
    chk(brownout_detect_enable, 1'b0);
    rd(12'h238, 8'h10);
    finish_test();
  end
endmodule : rcs_reset_cause_seq_bench
`default_nettype wire
